// File: logic/adcmc_pkg.sv
// Package of constants for the converter channel and mode control block.
// Assumes an 8-bit special function register port on the core clock.
package adcmc_pkg;

	// ------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_PRIMARY   = 8'hD8;
	localparam logic [7:0] ADDR_CTRL_SECONDARY = 8'hDC;
	localparam logic [7:0] ADDR_RESULT_LOW     = 8'hD9;
	localparam logic [7:0] ADDR_RESULT_HIGH    = 8'hDA;
	localparam logic [7:0] ADDR_IRQ_STATUS     = 8'hC0;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int POS_ACTIVE    = 4;
	localparam int POS_CONT_MODE = 3;
	localparam int POS_IRQ_FLAG  = 0;
	localparam int CHAN_W        = 3;
	localparam int RESULT_W      = 10;

	// ------------------------------------------------------------------
	// Reset values (undefined bits held at zero)
	// ------------------------------------------------------------------
	localparam logic [2:0] RST_PRIMARY_TOP   = 3'h0;
	localparam logic [1:0] RST_SECONDARY_TOP = 2'h1;
	localparam logic [2:0] RST_CHANNEL       = 3'h0;
	localparam logic [7:0] RST_RESULT        = 8'h00;

endpackage

// File: logic/adcmc_seq.sv
// Conversion sequencer: single and continuous start, active flag, channel latch.
// Assumes done from the analog engine is a one-cycle pulse on the same clock.
`timescale 1ns/1ps

module adcmc_seq (
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	adcmc_seq_if.seq  bus
);
	typedef enum logic {ADCMC_IDLE, ADCMC_RUN} adcmc_state_t;

	adcmc_state_t                 state_reg,  state_next;
	logic                         start_reg,  start_next;
	logic                         ran_reg,    ran_next;
	logic                         mode_d_reg, mode_d_next;
	logic [adcmc_pkg::CHAN_W-1:0] chan_reg,   chan_next;
	logic                         go;

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		state_next  = state_reg;
		start_next  = 1'b0;
		ran_next    = ran_reg;
		mode_d_next = bus.cont_mode;
		chan_next   = chan_reg;
		go          = 1'b0;
		// Setting the mode bit while idle restarts only after a first conversion
		if (bus.start_req) begin
			go = 1'b1; // RULE_08
		end else if (state_reg == ADCMC_IDLE) begin
			go = bus.cont_mode && !mode_d_reg && ran_reg; // RULE_02
		end
		unique case (state_reg)
			ADCMC_IDLE: begin
				if (go) begin
					state_next = ADCMC_RUN;
				end
			end
			ADCMC_RUN: begin
				if (bus.conv_done) begin
					ran_next  = 1'b1; // Enables the idle restart on mode set
					if (bus.cont_mode) begin
						go = 1'b1; // RULE_02
					end else if (!go) begin
						state_next = ADCMC_IDLE; // RULE_01 RULE_03
					end
				end
			end
		endcase
		if (go) begin
			start_next = 1'b1;
			chan_next  = bus.channel; // RULE_11
		end
	end

	// ------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_reg  <= ADCMC_IDLE;
			start_reg  <= 1'b0;
			ran_reg    <= 1'b0;
			mode_d_reg <= 1'b0;
			chan_reg   <= adcmc_pkg::RST_CHANNEL;
		end else begin
			state_reg  <= state_next;
			start_reg  <= start_next;
			ran_reg    <= ran_next;
			mode_d_reg <= mode_d_next;
			chan_reg   <= chan_next;
		end
	end

	// Outputs toward the register file and the engine
	assign bus.active       = (state_reg == ADCMC_RUN); // RULE_01
	// Completion is flagged in the done cycle, while the result is still valid
	assign bus.done_evt     = bus.conv_done && (state_reg == ADCMC_RUN); // RULE_09
	assign bus.conv_start   = start_reg;
	assign bus.conv_channel = chan_reg; // RULE_06
endmodule

// File: logic/adcmc_seq_if.sv
// Interface between the register file and the conversion sequencer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps

interface adcmc_seq_if;
	logic                            start_req;
	logic                            cont_mode;
	logic [adcmc_pkg::CHAN_W-1:0]    channel;
	logic                            conv_done;
	logic                            active;
	logic                            done_evt;
	logic                            conv_start;
	logic [adcmc_pkg::CHAN_W-1:0]    conv_channel;

	modport regs (
		output start_req,
		output cont_mode,
		output channel,
		output conv_done,
		input  active,
		input  done_evt,
		input  conv_start,
		input  conv_channel
	);

	modport seq (
		input  start_req,
		input  cont_mode,
		input  channel,
		input  conv_done,
		output active,
		output done_evt,
		output conv_start,
		output conv_channel
	);
endinterface

// File: logic/adcmc_top.sv
// Channel and mode control of a 10-bit converter, special function register side.
// Assumes the analog engine answers each start with one done pulse and a result.
// Overview of operation
// RULE_01: Active flag reads 1 throughout a conversion, cleared by hardware at its end.
// RULE_02: Continuous mode runs conversions back to back; single mode one per start.
// RULE_03: Clearing continuous mode mid-conversion lets it finish, then no further start.
// RULE_04: One shared 3-bit channel field appears in both control registers.
// RULE_05: Latest write through either control register sets the shared channel.
// RULE_06: Channel field is a binary index: value n selects analog input n.
// RULE_07: Reset values: primary 00X00000, secondary 01XXX000; X bits undefined.
// RULE_08: Any write to the low result register starts a conversion.
// RULE_09: Interrupt flag set at each completion; only software clears it.
// RULE_10: Result left justified: MSB at high bit 7, LSB at low bit 6.
// RULE_11: Channel sampled at conversion start; later changes apply to next one.
`timescale 1ns/1ps

module adcmc_top (
	input  wire logic                            i_clk_sys,
	input  wire logic                            i_rst,
	input  wire logic [7:0]                      i_sfr_addr,
	input  wire logic [7:0]                      i_sfr_wdata,
	input  wire logic                            i_sfr_wr,
	input  wire logic                            i_sfr_rd,
	output logic      [7:0]                      o_sfr_rdata,
	input  wire logic                            i_conv_done,
	input  wire logic [adcmc_pkg::RESULT_W-1:0]  i_conv_result,
	output logic                                 o_conv_start,
	output logic      [adcmc_pkg::CHAN_W-1:0]    o_conv_channel,
	output logic                                 o_conv_active,
	output logic                                 o_irq_flag
);
	adcmc_seq_if seq_bus ();

	logic [2:0]                   prim_top_reg, prim_top_next;
	logic [1:0]                   sec_top_reg,  sec_top_next;
	logic                         mode_reg,     mode_next;
	logic [adcmc_pkg::CHAN_W-1:0] chan_reg,     chan_next;
	logic [7:0]                   res_lo_reg,   res_lo_next;
	logic [7:0]                   res_hi_reg,   res_hi_next;
	logic                         irq_reg,      irq_next;
	logic [7:0]                   rdata_reg,    rdata_next;
	logic                         wr_prim;
	logic                         wr_sec;
	logic                         wr_lo;
	logic                         wr_hi;
	logic                         wr_irq;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// The sequencer owns the start pulse, the active flag and the channel latch
	adcmc_seq u_seq (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.bus       (seq_bus.seq)
	);

	// Register file drives the sequencer inputs
	assign seq_bus.start_req = wr_lo; // RULE_08
	assign seq_bus.cont_mode = mode_reg;
	assign seq_bus.channel   = chan_reg;
	assign seq_bus.conv_done = i_conv_done;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// One write strobe per mapped register; writes elsewhere are ignored
	assign wr_prim = i_sfr_wr && (i_sfr_addr == adcmc_pkg::ADDR_CTRL_PRIMARY);
	assign wr_sec  = i_sfr_wr && (i_sfr_addr == adcmc_pkg::ADDR_CTRL_SECONDARY);
	assign wr_lo   = i_sfr_wr && (i_sfr_addr == adcmc_pkg::ADDR_RESULT_LOW);
	assign wr_hi   = i_sfr_wr && (i_sfr_addr == adcmc_pkg::ADDR_RESULT_HIGH);
	assign wr_irq  = i_sfr_wr && (i_sfr_addr == adcmc_pkg::ADDR_IRQ_STATUS);

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	// Both control registers write the single channel field; last write wins
	always_comb begin
		prim_top_next = prim_top_reg;
		sec_top_next  = sec_top_reg;
		mode_next     = mode_reg;
		chan_next     = chan_reg;
		if (wr_prim) begin
			prim_top_next = i_sfr_wdata[7:5];
			mode_next     = i_sfr_wdata[adcmc_pkg::POS_CONT_MODE];
			chan_next     = i_sfr_wdata[adcmc_pkg::CHAN_W-1:0]; // RULE_05
		end
		if (wr_sec) begin
			sec_top_next = i_sfr_wdata[7:6];
			chan_next    = i_sfr_wdata[adcmc_pkg::CHAN_W-1:0]; // RULE_05
		end
	end

	// Control storage; the active bit has none here, so writes to it are lost
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			prim_top_reg <= adcmc_pkg::RST_PRIMARY_TOP; // RULE_07
			sec_top_reg  <= adcmc_pkg::RST_SECONDARY_TOP; // RULE_07
			mode_reg     <= 1'b0;
			chan_reg     <= adcmc_pkg::RST_CHANNEL;
		end else begin
			prim_top_reg <= prim_top_next;
			sec_top_reg  <= sec_top_next;
			mode_reg     <= mode_next;
			chan_reg     <= chan_next;
		end
	end

	// ------------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------------
	// Result registers are also writable as plain storage
	always_comb begin
		res_lo_next = res_lo_reg;
		res_hi_next = res_hi_reg;
		if (wr_lo) begin
			res_lo_next = i_sfr_wdata;
		end
		if (wr_hi) begin
			res_hi_next = i_sfr_wdata;
		end
		// Engine result, taken in its done cycle, overrides a same-cycle write
		if (seq_bus.done_evt) begin
			res_hi_next = res_hold_hi(i_conv_result);
			res_lo_next = res_hold_lo(i_conv_result);
		end
	end

	// Result storage, kept until the next conversion or software write
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			res_lo_reg <= adcmc_pkg::RST_RESULT;
			res_hi_reg <= adcmc_pkg::RST_RESULT;
		end else begin
			res_lo_reg <= res_lo_next;
			res_hi_reg <= res_hi_next;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt request flag
	// ------------------------------------------------------------------
	// Software clears the flag; a completion in the same cycle wins
	always_comb begin
		irq_next = irq_reg;
		if (wr_irq && !i_sfr_wdata[adcmc_pkg::POS_IRQ_FLAG]) begin
			irq_next = 1'b0;
		end
		if (seq_bus.done_evt) begin
			irq_next = 1'b1; // RULE_09
		end
	end

	// Sticky flag storage; hardware never clears it
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// ------------------------------------------------------------------
	// Read data multiplexer
	// ------------------------------------------------------------------
	always_comb begin
		rdata_next = rdata_reg;
		if (i_sfr_rd) begin
			unique case (i_sfr_addr)
				adcmc_pkg::ADDR_CTRL_PRIMARY: begin
					rdata_next = {prim_top_reg, seq_bus.active, mode_reg, chan_reg}; // RULE_04
				end
				adcmc_pkg::ADDR_CTRL_SECONDARY: begin
					rdata_next = {sec_top_reg, 3'h0, chan_reg}; // RULE_04
				end
				adcmc_pkg::ADDR_RESULT_LOW: begin
					rdata_next = res_lo_reg;
				end
				adcmc_pkg::ADDR_RESULT_HIGH: begin
					rdata_next = res_hi_reg;
				end
				adcmc_pkg::ADDR_IRQ_STATUS: begin
					rdata_next = {7'h00, irq_reg};
				end
				default: begin
					// Unmapped addresses read as zero
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Read data register
	// ------------------------------------------------------------------
	// Read data stands from the cycle after the read until the next read
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------------
	// Left-justified result split
	// ------------------------------------------------------------------
	function automatic logic [7:0] res_hold_hi(input logic [9:0] r);
		res_hold_hi = r[9:2]; // RULE_10
	endfunction

	function automatic logic [7:0] res_hold_lo(input logic [9:0] r);
		res_hold_lo = {r[1:0], 6'h00}; // RULE_10
	endfunction

	// Outputs, each from a flip-flop
	// Engine-side outputs come from the sequencer's own registers
	assign o_sfr_rdata    = rdata_reg;
	assign o_conv_start   = seq_bus.conv_start;
	assign o_conv_channel = seq_bus.conv_channel;
	assign o_conv_active  = seq_bus.active;
	assign o_irq_flag     = irq_reg;
endmodule

// File: verification/adcmc_properties.sv
// Port-level checks for the converter channel and mode control block.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps

module adcmc_properties (
	input wire logic       i_clk_sys,
	input wire logic       i_rst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic       i_sfr_wr,
	input wire logic       i_sfr_rd,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic       i_conv_done,
	input wire logic [9:0] i_conv_result,
	input wire logic       o_conv_start,
	input wire logic [2:0] o_conv_channel,
	input wire logic       o_conv_active,
	input wire logic       o_irq_flag
);
	logic mode_reg;
	logic mode_next;
	logic run_end;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	// Mirror of the continuous mode bit, taken from primary writes
	always_comb begin
		mode_next = mode_reg;
		if (i_sfr_wr && i_sfr_addr == adcmc_pkg::ADDR_CTRL_PRIMARY) begin
			mode_next = i_sfr_wdata[adcmc_pkg::POS_CONT_MODE];
		end
	end
	always_ff @(posedge i_clk_sys) begin
		mode_reg <= i_rst ? 1'b0 : mode_next;
	end
	// Completion of a running conversion with no start pulse or register write beside it
	assign run_end = i_conv_done && o_conv_active && !o_conv_start && !i_sfr_wr;

	property p_start_active; o_conv_start |-> o_conv_active; endproperty
	a_start_active: assert property (p_start_active) else $error("start without active");
	property p_low_wr_start;
		i_sfr_wr && i_sfr_addr == adcmc_pkg::ADDR_RESULT_LOW |=> o_conv_start && o_conv_active;
	endproperty
	a_low_wr_start: assert property (p_low_wr_start) else $error("no start");
	property p_single_end; run_end && !mode_reg |=> !o_conv_active && !o_conv_start; endproperty
	a_single_end: assert property (p_single_end) else $error("run did not stop");
	property p_cont_again; run_end && mode_reg |=> o_conv_start && o_conv_active; endproperty
	a_cont_again: assert property (p_cont_again) else $error("no restart");
	property p_irq_set; run_end |=> o_irq_flag; endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq not set");
	property p_irq_hold;
		o_irq_flag && !(i_sfr_wr && i_sfr_addr == adcmc_pkg::ADDR_IRQ_STATUS) |=> o_irq_flag;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
	property p_chan_latch; $changed(o_conv_channel) |-> o_conv_start; endproperty
	a_chan_latch: assert property (p_chan_latch) else $error("channel moved");
	property p_busy_read;
		i_sfr_rd && i_sfr_addr == adcmc_pkg::ADDR_CTRL_PRIMARY
			|=> o_sfr_rdata[adcmc_pkg::POS_ACTIVE] == $past(o_conv_active);
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("active bit wrong");

	c_restart: cover property (run_end && mode_reg);
	c_irq_clear: cover property (o_irq_flag ##1 !o_irq_flag);
	c_start: cover property (o_conv_start);
endmodule

bind adcmc_top adcmc_properties adcmc_properties_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
	.i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr),
	.i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .i_conv_done(i_conv_done),
	.i_conv_result(i_conv_result), .o_conv_start(o_conv_start),
	.o_conv_channel(o_conv_channel), .o_conv_active(o_conv_active), .o_irq_flag(o_irq_flag));

// File: verification/tb.sv
// Self-checking bench for the converter channel and mode control block.
// Assumes the register map and engine timing of the block's package.
`timescale 1ns/1ps

module tb;
	logic       i_clk_sys     = 1'b0;
	logic       i_rst         = 1'b1;
	logic [7:0] i_sfr_addr    = 8'h00;
	logic [7:0] i_sfr_wdata   = 8'h00;
	logic       i_sfr_wr      = 1'b0;
	logic       i_sfr_rd      = 1'b0;
	logic       i_conv_done   = 1'b0;
	logic [9:0] i_conv_result = 10'h000;
	logic [7:0] o_sfr_rdata;
	logic       o_conv_start;
	logic [2:0] o_conv_channel;
	logic       o_conv_active;
	logic       o_irq_flag;
	logic [7:0] rnd;
	int         num_errors    = 0;
	int         comparisons   = 0;
	int         cycles        = 0;
	int         seed          = 19630;
	int         m_ptop        = 0;
	int         m_stop        = 1;
	int         m_mode        = 0;
	int         m_chan        = 0;
	int         m_res         = 0;
	int         exp_q[$];

	adcmc_top adcmc_top_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
		.i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
		.o_sfr_rdata(o_sfr_rdata), .i_conv_done(i_conv_done), .i_conv_result(i_conv_result),
		.o_conv_start(o_conv_start), .o_conv_channel(o_conv_channel),
		.o_conv_active(o_conv_active), .o_irq_flag(o_irq_flag));

	// Clock and hang guard
	always #50 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			test_done();
		end
	end

	// -----------------------------------------------------------------
	// Bus tasks and model values
	// -----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_sfr_wr <= 1'b1;
		i_sfr_addr <= a;
		i_sfr_wdata <= d;
		@(posedge i_clk_sys);
		i_sfr_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk_sys);
		i_sfr_rd <= 1'b1;
		i_sfr_addr <= a;
		@(posedge i_clk_sys);
		i_sfr_rd <= 1'b0;
		#1;
		chk(o_sfr_rdata, exp, "register read");
	endtask
	task automatic done_pulse;
		m_res = $random(seed) & 32'h000003FF;
		exp_q.push_back(m_res);
		@(posedge i_clk_sys);
		i_conv_done <= 1'b1;
		i_conv_result <= 10'(m_res);
		@(posedge i_clk_sys);
		i_conv_done <= 1'b0;
		#1;
	endtask
	function automatic logic [7:0] e_pri(input logic act);
		return {m_ptop[2:0], act, m_mode[0], m_chan[2:0]};
	endfunction
	task automatic test_done;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Reset, channel sweep with single conversions, then continuous mode
	initial begin
		repeat (6) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		rd(adcmc_pkg::ADDR_CTRL_PRIMARY, 8'h00);
		rd(adcmc_pkg::ADDR_CTRL_SECONDARY, 8'h40);
		rd(8'h55, 8'h00);
		for (int n = 0; n < 5; n++) begin
			rnd = 8'($random(seed));
			m_chan = n;
			if (n % 2 == 0) begin
				m_ptop = rnd[7:5];
				wr(adcmc_pkg::ADDR_CTRL_PRIMARY, e_pri(1'b0));
			end else begin
				m_stop = rnd[7:6];
				wr(adcmc_pkg::ADDR_CTRL_SECONDARY, {rnd[7:3], m_chan[2:0]});
			end
			rd(adcmc_pkg::ADDR_CTRL_SECONDARY, {m_stop[1:0], 3'h0, m_chan[2:0]});
			wr(adcmc_pkg::ADDR_RESULT_LOW, rnd);
			chk({6'h00, o_conv_start, o_conv_active}, 8'h03, "start");
			chk(8'(o_conv_channel), 8'(n), "channel");
			wr(adcmc_pkg::ADDR_RESULT_LOW, 8'h00);
			chk({6'h00, o_conv_start, o_conv_active}, 8'h03, "restart on write");
			m_chan = (n + 1) % 5;
			wr(adcmc_pkg::ADDR_CTRL_PRIMARY, e_pri(1'b0));
			rd(adcmc_pkg::ADDR_CTRL_PRIMARY, e_pri(1'b1));
			chk(8'(o_conv_channel), 8'(n), "latched channel");
			done_pulse();
			chk({5'h00, o_conv_start, o_conv_active, o_irq_flag}, 8'h01, "end");
			m_res = exp_q.pop_front();
			rd(adcmc_pkg::ADDR_RESULT_HIGH, 8'(m_res >> 2));
			rd(adcmc_pkg::ADDR_RESULT_LOW, {m_res[1:0], 6'h00});
			wr(adcmc_pkg::ADDR_IRQ_STATUS, 8'h00);
			rd(adcmc_pkg::ADDR_IRQ_STATUS, 8'h00);
		end
		m_mode = 1;
		wr(adcmc_pkg::ADDR_CTRL_PRIMARY, e_pri(1'b0));
		for (int k = 0; k < 4 && o_conv_start !== 1'b1; k++) @(posedge i_clk_sys) #1;
		chk(8'(o_conv_start), 8'h01, "mode start");
		done_pulse();
		chk({6'h00, o_conv_start, o_conv_active}, 8'h03, "restart");
		m_mode = 0;
		wr(adcmc_pkg::ADDR_CTRL_PRIMARY, e_pri(1'b0));
		done_pulse();
		repeat (3) @(posedge i_clk_sys);
		#1;
		chk({6'h00, o_conv_start, o_conv_active}, 8'h00, "stop");
		m_res = exp_q[$];
		rd(adcmc_pkg::ADDR_RESULT_HIGH, 8'(m_res >> 2));
		rd(adcmc_pkg::ADDR_RESULT_LOW, {m_res[1:0], 6'h00});
		rnd = 8'($random(seed));
		wr(adcmc_pkg::ADDR_RESULT_HIGH, rnd);
		rd(adcmc_pkg::ADDR_RESULT_HIGH, rnd);
		test_done();
	end
endmodule
